// File: mmci_core.v
// midi mixer control interpreter: decodes parsed channel messages into
// track status, scene, effect patch and parameter updates; holds sync and
// metronome settings. assumes an upstream parser delivers whole messages.
`timescale 1ns/1ps
`include "mmci_defs.vh"

module mmci_core #(
  parameter NUM_TRACKS = 18,
  parameter NUM_FX = 4
)
(
  // clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // ahb-lite slave
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // parsed incoming channel message
  input wire msg_valid,
  input wire [3:0] msg_kind,
  input wire [3:0] msg_chan,
  input wire [6:0] msg_d1,
  input wire [6:0] msg_d2,
  // metronome beat events
  input wire beat_tick,
  input wire beat_accent,
  // transport and effects
  output reg transport_halt,
  output reg [NUM_FX-1:0] fx_param_stb,
  output reg [6:0] fx_param_num,
  output reg [6:0] fx_param_val,
  // sync and outgoing midi
  output wire tempo_map_clock_out,
  output wire sync_track_clock_out,
  output wire mtc_out_en,
  output wire midi_thru_sel,
  output reg click_note_stb,
  output reg [3:0] click_channel,
  output reg [6:0] click_note,
  output reg [6:0] click_velocity,
  output wire int_click_en,
  output wire [6:0] int_click_level
);

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  reg [31:0] ctrl_q;
  reg [31:0] metro_q;
  reg [13:0] velo_q;
  reg [2*NUM_TRACKS-1:0] trk_q;
  reg [2:0] scene_q;
  wire [3*NUM_FX-1:0] bank_all;
  wire [8*NUM_FX-1:0] patch_all;
  wire [NUM_FX-1:0] patch_user_all;
  reg [3:0] halt_cnt_q;
  reg halt_pend_q;
  reg [2:0] pend_scene_q;
  reg [7:0] ign_cnt_q;

  // ahb address phase capture
  reg dp_wr_q;
  reg dp_rd_q;
  reg [11:0] dp_addr_q;

  wire scene_en = ctrl_q[`MMCI_CTL_SCENE_EN];
  wire eff_en = ctrl_q[`MMCI_CTL_EFF_EN];
  wire cceff_en = ctrl_q[`MMCI_CTL_CCEFF_EN];
  wire auto_punch = ctrl_q[`MMCI_CTL_AUTO_PUNCH];
  wire [1:0] sync_sel = ctrl_q[`MMCI_CTL_SYNC_LSB+1:`MMCI_CTL_SYNC_LSB];
  wire [1:0] xport = ctrl_q[`MMCI_CTL_XPORT_LSB+1:`MMCI_CTL_XPORT_LSB];
  wire [1:0] dest = metro_q[`MMCI_MET_DEST_LSB+1:`MMCI_MET_DEST_LSB];
  wire met_play = metro_q[`MMCI_MET_MODE];

  wire is_stop = (xport == `MMCI_XP_STOP);
  wire is_rec = (xport == `MMCI_XP_REC);
  wire is_play = (xport == `MMCI_XP_PLAY);

  // ----------------------------------------
  // sync source and connector function
  // ----------------------------------------
  // gates only; clock and time code generators sit downstream
  assign mtc_out_en = (sync_sel == `MMCI_SYNC_MTC) & ~midi_thru_sel;
  assign tempo_map_clock_out = (sync_sel == `MMCI_SYNC_TEMPO) & ~midi_thru_sel;
  assign sync_track_clock_out = (sync_sel == `MMCI_SYNC_TRACK) & ~midi_thru_sel;
  assign midi_thru_sel = ctrl_q[`MMCI_CTL_THRU];

  // ----------------------------------------
  // track status decode
  // ----------------------------------------
  wire is_cc = msg_valid & (msg_kind == `MMCI_STAT_CC);
  wire is_pc = msg_valid & (msg_kind == `MMCI_STAT_PC);
  wire cc_lo = is_cc & (msg_d1 == `MMCI_CC_STATUS);
  wire cc_hi = is_cc & (msg_d1 == `MMCI_CC_STATUS_HI) & (msg_chan < 4'h2);
  wire [4:0] trk_idx = cc_hi ? (5'h10 + {1'b0, msg_chan}) : {1'b0, msg_chan};
  wire [1:0] want = msg_d2[6:5];

  function [1:0] next_status;
    input [1:0] cur;
    input [1:0] req;
    input stopped;
    input recording;
    input punch;
    reg [1:0] r;
    begin
      r = cur;
      if (stopped)
      begin
        r = req;
      end
      else
      begin
        // only the listed transitions; the rest leave status alone
        if (req == `MMCI_TRK_MUTE && (cur == `MMCI_TRK_PLAY || cur == `MMCI_TRK_SRC))
          r = `MMCI_TRK_MUTE;
        else if (req == `MMCI_TRK_PLAY && cur == `MMCI_TRK_MUTE)
          r = `MMCI_TRK_PLAY;
        else if (req == `MMCI_TRK_SRC && cur == `MMCI_TRK_REC && !recording)
          r = `MMCI_TRK_SRC;
        else if (req == `MMCI_TRK_REC && cur == `MMCI_TRK_SRC && !recording)
          r = `MMCI_TRK_REC;
      end
      if (r == `MMCI_TRK_SRC && !punch)
        r = cur;
      next_status = r;
    end
  endfunction

  // ----------------------------------------
  // program change decode
  // ----------------------------------------
  wire scene_req = is_pc & (msg_chan == `MMCI_CH_SCENE) & scene_en & ~is_rec;
  wire scene_ok = scene_req & (msg_d1 < `MMCI_NUM_SCENES);
  wire fx_ch = (msg_chan < NUM_FX);
  wire [1:0] fx_idx = msg_chan[1:0];
  wire [2:0] cur_bank = bank_all[3*fx_idx +: 3];
  wire [6:0] prog_lim = (cur_bank == 3'h2) ? `MMCI_PROG_SHORT : `MMCI_PROG_FULL;
  wire fx_pc = is_pc & fx_ch & eff_en;
  wire fx_pc_ok = fx_pc & (cur_bank <= `MMCI_BANK_LAST) & (msg_d1 < prog_lim);
  // user banks restart patch numbering at zero
  wire [2:0] bank_rel = (cur_bank >= `MMCI_BANK_USER) ? (cur_bank - `MMCI_BANK_USER) : cur_bank;
  wire [8:0] patch_full = (bank_rel[0] ? `MMCI_BANK_STEP : 9'h000) + (bank_rel[1] ? 9'h0C8 : 9'h000)
    + {2'h0, msg_d1};
  wire cc_bank_msb = is_cc & fx_ch & (msg_d1 == `MMCI_CC_BANK_MSB);
  wire cc_bank_lsb = is_cc & fx_ch & (msg_d1 == `MMCI_CC_BANK_LSB);
  wire cc_fx = is_cc & fx_ch & cceff_en & ~cc_lo & ~cc_hi & ~cc_bank_msb & ~cc_bank_lsb;

  // ----------------------------------------
  // per effect unit bank and patch
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_FX; g = g + 1)
    begin : g_unit
      reg [2:0] bank_q;
      reg [7:0] patch_q;
      reg user_q;
      // unit chosen by channel; channels past the last unit never match
      wire hit = fx_ch & (fx_idx == g);
      always @(posedge ref_clk)
      begin
        if (sys_rst)
        begin
          bank_q <= 3'h0;
          patch_q <= 8'h00;
          user_q <= 1'b0;
        end
        else if (hit)
        begin
          // nonzero bank msb parks the unit on an unmapped bank
          if (cc_bank_msb && msg_d2 != 7'h00)
            bank_q <= 3'h7;
          else if (cc_bank_lsb)
            bank_q <= (msg_d2 > 7'h04) ? 3'h7 : msg_d2[2:0];
          // program is judged against the bank held before this message
          if (fx_pc_ok)
          begin
            patch_q <= patch_full[7:0];
            user_q <= (cur_bank >= `MMCI_BANK_USER);
          end
        end
      end
      assign bank_all[3*g +: 3] = bank_q;
      assign patch_all[8*g +: 8] = patch_q;
      assign patch_user_all[g] = user_q;
    end
  endgenerate

  // ----------------------------------------
  // message processing
  // ----------------------------------------
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      trk_q <= {2*NUM_TRACKS{1'b0}};
      scene_q <= 3'h0;
      halt_cnt_q <= 4'h0;
      halt_pend_q <= 1'b0;
      pend_scene_q <= 3'h0;
      transport_halt <= 1'b0;
      fx_param_stb <= {NUM_FX{1'b0}};
      fx_param_num <= 7'h00;
      fx_param_val <= 7'h00;
      ign_cnt_q <= 8'h00;
    end
    else
    begin
      fx_param_stb <= {NUM_FX{1'b0}};
      if (cc_lo || cc_hi)
        trk_q[2*trk_idx +: 2] <= next_status(trk_q[2*trk_idx +: 2], want, is_stop, is_rec, auto_punch);
      if (cc_fx)
      begin
        fx_param_stb[fx_idx] <= 1'b1;
        fx_param_num <= msg_d1;
        fx_param_val <= msg_d2;
      end
      if ((scene_req && !scene_ok) || (fx_pc && !fx_pc_ok))
        ign_cnt_q <= ign_cnt_q + 8'h01;
      // halt while playing, apply scene, release after a few cycles
      if (scene_ok && is_play)
      begin
        transport_halt <= 1'b1;
        halt_pend_q <= 1'b1;
        pend_scene_q <= msg_d1[2:0];
        halt_cnt_q <= `MMCI_HALT_CYC;
      end
      else if (scene_ok)
        scene_q <= msg_d1[2:0];
      else if (halt_pend_q)
      begin
        if (halt_cnt_q == `MMCI_HALT_CYC)
          scene_q <= pend_scene_q;
        if (halt_cnt_q == 4'h0)
        begin
          transport_halt <= 1'b0;
          halt_pend_q <= 1'b0;
        end
        else
          halt_cnt_q <= halt_cnt_q - 4'h1;
      end
    end
  end

  // ----------------------------------------
  // metronome
  // ----------------------------------------
  wire click_time = is_rec | (is_play & met_play);
  assign int_click_en = click_time & (dest == `MMCI_DEST_INT);
  assign int_click_level = metro_q[`MMCI_MET_LVL_LSB+6:`MMCI_MET_LVL_LSB];

  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      click_note_stb <= 1'b0;
      click_channel <= 4'h0;
      click_note <= 7'h00;
      click_velocity <= 7'h00;
    end
    else
    begin
      click_note_stb <= beat_tick & click_time & (dest == `MMCI_DEST_MIDI);
      if (beat_tick)
      begin
        click_channel <= metro_q[`MMCI_MET_CH_LSB+3:`MMCI_MET_CH_LSB];
        click_note <= beat_accent ? metro_q[`MMCI_MET_ACCN_LSB+6:`MMCI_MET_ACCN_LSB]
          : metro_q[`MMCI_MET_NRMN_LSB+6:`MMCI_MET_NRMN_LSB];
        click_velocity <= beat_accent ? velo_q[13:7] : velo_q[6:0];
      end
    end
  end

  // ----------------------------------------
  // ahb-lite slave, zero wait states
  // ----------------------------------------
  wire ap_valid = hsel & hready & htrans[`MMCI_HTRANS_NONSEQ];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // velocity 0 coerced to 1; level and notes kept 7 bits
  wire [6:0] wv_acc = (hwdata[13:7] == 7'h00) ? 7'h01 : hwdata[13:7];
  wire [6:0] wv_nrm = (hwdata[6:0] == 7'h00) ? 7'h01 : hwdata[6:0];

  // unit 3 patch top nibble is not readable; the user flags take its place
  wire [31:0] effect_word = {patch_user_all, patch_all[27:0]};
  wire [31:0] scene_word = {8'h00, ign_cnt_q, halt_pend_q, bank_all[11:0], scene_q};

  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      dp_wr_q <= 1'b0;
      dp_rd_q <= 1'b0;
      dp_addr_q <= 12'h000;
      ctrl_q <= `MMCI_CTL_RESET;
      metro_q <= `MMCI_MET_RESET;
      velo_q <= `MMCI_VELO_RESET;
      hrdata <= 32'h0000_0000;
    end
    else
    begin
      dp_wr_q <= ap_valid & hwrite;
      dp_rd_q <= ap_valid & ~hwrite;
      if (ap_valid)
        dp_addr_q <= haddr;
      if (dp_wr_q)
      begin
        if (dp_addr_q == `MMCI_REG_CTRL)
          ctrl_q <= {23'h0, hwdata[8:0]};
        else if (dp_addr_q == `MMCI_REG_METRO)
          metro_q <= {1'b0, hwdata[30:24], 1'b0, hwdata[22:16], 1'b0, hwdata[14:8],
            hwdata[7:4], 1'b0, hwdata[2:0]};
        else if (dp_addr_q == `MMCI_REG_MSG)
          velo_q <= {wv_acc, wv_nrm};
      end
      // read data registered at the address phase edge
      if (ap_valid && !hwrite)
      begin
        if (haddr == `MMCI_REG_CTRL)
          hrdata <= ctrl_q;
        else if (haddr == `MMCI_REG_METRO)
          hrdata <= metro_q;
        else if (haddr == `MMCI_REG_MSG)
          hrdata <= {18'h0, velo_q};
        else if (haddr == `MMCI_REG_EFFECT)
          hrdata <= effect_word;
        else if (haddr == `MMCI_REG_SCENE)
          hrdata <= scene_word;
        else if (haddr == `MMCI_REG_TRK_LO)
          hrdata <= trk_q[31:0];
        else if (haddr == `MMCI_REG_TRK_HI)
          hrdata <= {28'h0, trk_q[35:32]};
        else if (haddr == `MMCI_REG_STATUS)
          hrdata <= {27'h0, transport_halt, click_time, xport, halt_pend_q};
        else
          hrdata <= 32'h0000_0000;
      end
    end
  end

endmodule // mmci_core

// File: mmci_defs.vh
// constants for the midi mixer control interpreter
// assumes inclusion by bare name from the design file
`ifndef MMCI_DEFS_VH
`define MMCI_DEFS_VH
// register byte offsets
`define MMCI_REG_CTRL 12'h000
`define MMCI_REG_METRO 12'h004
`define MMCI_REG_MSG 12'h008
`define MMCI_REG_EFFECT 12'h00C
`define MMCI_REG_SCENE 12'h010
`define MMCI_REG_TRK_LO 12'h014
`define MMCI_REG_TRK_HI 12'h018
`define MMCI_REG_STATUS 12'h01C
// control register fields
`define MMCI_CTL_SCENE_EN 0
`define MMCI_CTL_EFF_EN 1
`define MMCI_CTL_CCEFF_EN 2
`define MMCI_CTL_AUTO_PUNCH 3
`define MMCI_CTL_THRU 4
`define MMCI_CTL_SYNC_LSB 5
`define MMCI_CTL_XPORT_LSB 7
`define MMCI_CTL_RESET 32'h0000_0000
// metronome register fields
`define MMCI_MET_DEST_LSB 0
`define MMCI_MET_MODE 2
`define MMCI_MET_CH_LSB 4
`define MMCI_MET_LVL_LSB 8
`define MMCI_MET_ACCN_LSB 16
`define MMCI_MET_NRMN_LSB 24
`define MMCI_VELO_RESET 14'h3F7F
`define MMCI_MET_RESET 32'h4C4D_6400
// encodings
`define MMCI_TRK_MUTE 2'h0
`define MMCI_TRK_PLAY 2'h1
`define MMCI_TRK_REC 2'h2
`define MMCI_TRK_SRC 2'h3
`define MMCI_XP_STOP 2'h0
`define MMCI_XP_PLAY 2'h1
`define MMCI_XP_REC 2'h2
`define MMCI_SYNC_OFF 2'h0
`define MMCI_SYNC_MTC 2'h1
`define MMCI_SYNC_TEMPO 2'h2
`define MMCI_SYNC_TRACK 2'h3
`define MMCI_DEST_OFF 2'h0
`define MMCI_DEST_INT 2'h1
`define MMCI_DEST_MIDI 2'h2
`define MMCI_STAT_CC 4'hB
`define MMCI_STAT_PC 4'hC
`define MMCI_CC_BANK_MSB 7'h00
`define MMCI_CC_BANK_LSB 7'h20
`define MMCI_CC_STATUS 7'h03
`define MMCI_CC_STATUS_HI 7'h23
`define MMCI_CH_SCENE 4'hF
`define MMCI_NUM_SCENES 7'h08
`define MMCI_PROG_FULL 7'h64
`define MMCI_PROG_SHORT 7'h0A
`define MMCI_BANK_STEP 9'h064
`define MMCI_BANK_USER 3'h3
`define MMCI_BANK_LAST 3'h4
`define MMCI_HALT_CYC 4'h4
`define MMCI_NOTE_MAX 7'h7F
`define MMCI_HTRANS_NONSEQ 1
`endif

// File: mmci_midi_peer.sv
// midi peer model: sends parsed messages, records click notes
// assumes send is called just after a rising clock edge
`timescale 1ns/1ps
module mmci_midi_peer (
  // clock
  input wire ref_clk,
  // messages toward the core
  output reg msg_valid = 1'b0,
  output reg [3:0] msg_kind = 4'h0,
  output reg [3:0] msg_chan = 4'h0,
  output reg [6:0] msg_d1 = 7'h00,
  output reg [6:0] msg_d2 = 7'h00,
  // click notes from the core
  input wire click_note_stb,
  input wire [3:0] click_channel,
  input wire [6:0] click_note,
  input wire [6:0] click_velocity
);
  integer n_click = 0;
  reg [17:0] last_click = 18'h00000;
  task send(input [3:0] k, input [3:0] c, input [6:0] a, input [6:0] b);
    begin
      @(posedge ref_clk);
      msg_valid <= 1'b1;
      msg_kind <= k;
      msg_chan <= c;
      msg_d1 <= a;
      msg_d2 <= b;
      @(posedge ref_clk);
      msg_valid <= 1'b0;
      // idle fields flip so a stale message never looks valid
      msg_kind <= ~k;
      msg_chan <= ~c;
      msg_d1 <= ~a;
      msg_d2 <= ~b;
    end
  endtask
  always @(posedge ref_clk)
  begin
    if (click_note_stb === 1'b1)
    begin
      n_click <= n_click + 1;
      last_click <= {click_channel, click_note, click_velocity};
    end
  end
endmodule // mmci_midi_peer

// File: mmci_monitor.sv
// checker for the control interpreter core, bound to every instance
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module mmci_monitor #(
  parameter NUM_FX = 4
)
(
  // clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // bus answer
  input wire hreadyout,
  input wire hresp,
  // causes
  input wire msg_valid,
  input wire [3:0] msg_kind,
  input wire [3:0] msg_chan,
  input wire beat_tick,
  // effects
  input wire transport_halt,
  input wire [NUM_FX-1:0] fx_param_stb,
  input wire tempo_map_clock_out,
  input wire sync_track_clock_out,
  input wire mtc_out_en,
  input wire midi_thru_sel,
  input wire click_note_stb,
  input wire [6:0] click_velocity
);
  wire pc_scene = msg_valid && msg_kind == 4'hC && msg_chan == 4'hF;
  wire cc_in = msg_valid && msg_kind == 4'hB;
  wire [2:0] sync_out = {sync_track_clock_out, tempo_map_clock_out, mtc_out_en};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  property p_ready; hreadyout == 1'b1; endproperty
  a_ready: assert property (p_ready) else $error("bus wait state seen");
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("bus error response seen");
  property p_halt_cause; $rose(transport_halt) |-> $past(pc_scene) || $past(pc_scene, 2); endproperty
  a_halt_cause: assert property (p_halt_cause) else $error("halt without scene change");
  property p_halt_len; $rose(transport_halt) |-> transport_halt [*5] ##[1:4] !transport_halt; endproperty
  a_halt_len: assert property (p_halt_len) else $error("halt length wrong");
  property p_fx_cause; |fx_param_stb |-> $onehot(fx_param_stb) && $past(cc_in); endproperty
  a_fx_cause: assert property (p_fx_cause) else $error("effect strobe without control change");
  property p_click_cause; click_note_stb |-> $past(beat_tick); endproperty
  a_click_cause: assert property (p_click_cause) else $error("click without beat");
  property p_click_velo; click_note_stb |-> click_velocity != 7'h00; endproperty
  a_click_velo: assert property (p_click_velo) else $error("click velocity zero");
  property p_thru; midi_thru_sel |-> sync_out == 3'h0; endproperty
  a_thru: assert property (p_thru) else $error("sync output while thru");
  property p_sync_one; $onehot0(sync_out); endproperty
  a_sync_one: assert property (p_sync_one) else $error("two sync outputs at once");
  c_halt: cover property ($rose(transport_halt));
  c_fx: cover property (|fx_param_stb);
  c_click: cover property (click_note_stb);
endmodule // mmci_monitor

bind mmci_core mmci_monitor #(.NUM_FX(NUM_FX)) u_mon (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .hreadyout(hreadyout), .hresp(hresp),
  .msg_valid(msg_valid), .msg_kind(msg_kind), .msg_chan(msg_chan), .beat_tick(beat_tick),
  .transport_halt(transport_halt), .fx_param_stb(fx_param_stb), .tempo_map_clock_out(tempo_map_clock_out),
  .sync_track_clock_out(sync_track_clock_out), .mtc_out_en(mtc_out_en), .midi_thru_sel(midi_thru_sel),
  .click_note_stb(click_note_stb), .click_velocity(click_velocity)
);

// File: tb_top.sv
// self-checking bench for the control interpreter core
// assumes the core, its checker and the midi peer model compile first
`timescale 1ns/1ps
`include "mmci_defs.vh"
module tb_top;
  localparam [31:0] m_all = 32'hFFFF_FFFF;
  reg ref_clk = 1'b0;
  reg sys_rst = 1'b1;
  reg hsel = 1'b0;
  reg [11:0] haddr = 12'h000;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h0000_0000;
  reg beat_tick = 1'b0;
  reg beat_accent = 1'b0;
  wire hreadyout, hresp, msg_valid, transport_halt, tempo_map_clock_out, sync_track_clock_out;
  wire mtc_out_en, midi_thru_sel, click_note_stb, int_click_en;
  wire [31:0] hrdata;
  wire [3:0] msg_kind, msg_chan, fx_param_stb, click_channel;
  wire [6:0] msg_d1, msg_d2, click_note, click_velocity, int_click_level, fx_param_num, fx_param_val;
  wire [2:0] sync_out_w = {sync_track_clock_out, tempo_map_clock_out, mtc_out_en};
  reg [3:0] fx_last = 4'h0;
  integer n_mismatch = 0;
  integer n_compared = 0;
  integer halt_cnt = 0;
  integer fx_cnt = 0;
  integer i;
  reg [1:0] trk [0:17];
  reg [31:0] q;

  mmci_core u_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .msg_valid(msg_valid), .msg_kind(msg_kind), .msg_chan(msg_chan), .msg_d1(msg_d1), .msg_d2(msg_d2),
    .beat_tick(beat_tick), .beat_accent(beat_accent), .transport_halt(transport_halt),
    .fx_param_stb(fx_param_stb), .fx_param_num(fx_param_num), .fx_param_val(fx_param_val),
    .tempo_map_clock_out(tempo_map_clock_out),
    .sync_track_clock_out(sync_track_clock_out), .mtc_out_en(mtc_out_en), .midi_thru_sel(midi_thru_sel),
    .click_note_stb(click_note_stb), .click_channel(click_channel), .click_note(click_note),
    .click_velocity(click_velocity), .int_click_en(int_click_en), .int_click_level(int_click_level)
  );
  mmci_midi_peer u_peer (
    .ref_clk(ref_clk), .msg_valid(msg_valid), .msg_kind(msg_kind), .msg_chan(msg_chan), .msg_d1(msg_d1),
    .msg_d2(msg_d2), .click_note_stb(click_note_stb), .click_channel(click_channel), .click_note(click_note),
    .click_velocity(click_velocity)
  );

  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    if (transport_halt === 1'b1) halt_cnt <= halt_cnt + 1;
    if (|fx_param_stb === 1'b1) fx_cnt <= fx_cnt + 1;
    if (|fx_param_stb === 1'b1) fx_last <= fx_param_stb;
  end

  // --------
  // checks and bus cycles
  // --------
  task check(input string what, input [31:0] exp, input [31:0] got);
    begin
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
        $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        n_mismatch = n_mismatch + 1;
      end
    end
  endtask
  task wait_rdy;
    begin
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
    end
  endtask
  task bus(input w, input [11:0] a, input [31:0] d);
    begin
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      wait_rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy;
      q = hrdata;
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rd(input string what, input [11:0] a, input [31:0] m, input [31:0] exp);
    begin
      bus(1'b0, a, 32'h0000_0000);
      check(what, exp, q & m);
    end
  endtask
  task tick(input acc);
    begin
      beat_tick <= 1'b1;
      beat_accent <= acc;
      @(posedge ref_clk);
      beat_tick <= 1'b0;
      repeat (3) @(posedge ref_clk);
    end
  endtask
  // expected track status after one controller 3 request
  function [1:0] nxt(input [1:0] c, input [1:0] r, input [1:0] xp, input pun);
    begin
      nxt = c;
      if (r == 2'h3 && !pun) nxt = c;
      else if (xp == 2'h0) nxt = r;
      else if (r == 2'h0 && c != 2'h2) nxt = r;
      else if (r == 2'h1 && c == 2'h0) nxt = r;
      else if (c[1] && r[1] && xp == 2'h1) nxt = r;
    end
  endfunction
  // every track gets one request; sel picks all eight status/value pairs
  task pass(input [1:0] xp, input pun, input sel);
    reg [1:0] r;
    reg [31:0] e;
    begin
      wr(`MMCI_REG_CTRL, {23'h0, xp, 3'h0, pun, 3'h0});
      for (i = 0; i < 18; i = i + 1)
      begin
        r = sel ? i[3:2] : i[1:0];
        u_peer.send(4'hB, i[3:0], i[4] ? 7'h23 : 7'h03, {r, i[0] ? 5'h1F : 5'h00});
        trk[i] = nxt(trk[i], r, xp, pun);
      end
      for (i = 0; i < 16; i = i + 1) e[2*i +: 2] = trk[i];
      rd("trk_lo", `MMCI_REG_TRK_LO, m_all, e);
      rd("trk_hi", `MMCI_REG_TRK_HI, 32'hF, {28'h0, trk[17], trk[16]});
    end
  endtask
  task complete_run;
    begin
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  initial
  begin
    #100000;
    n_mismatch = n_mismatch + 1;
    complete_run;
  end

  // --------
  // main sequence
  // --------
  initial
  begin
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    rd("ctrl", `MMCI_REG_CTRL, m_all, 32'h0000_0000);
    rd("metro", `MMCI_REG_METRO, m_all, 32'h4C4D_6400);
    rd("velo", `MMCI_REG_MSG, m_all, 32'h0000_3F7F);
    rd("unmapped", 12'h100, m_all, 32'h0000_0000);
    pass(2'h0, 1'b1, 1'b0);
    pass(2'h1, 1'b1, 1'b1);
    pass(2'h0, 1'b1, 1'b0);
    pass(2'h2, 1'b1, 1'b1);
    pass(2'h0, 1'b0, 1'b1);
    check("fx_quiet", 32'h0, fx_cnt);
    wr(`MMCI_REG_CTRL, 32'h0000_0001);
    u_peer.send(4'hC, 4'hF, 7'h04, 7'h00);
    rd("scene", `MMCI_REG_SCENE, 32'h7, 32'h4);
    u_peer.send(4'hC, 4'hF, 7'h08, 7'h00);
    u_peer.send(4'hC, 4'h0, 7'h02, 7'h00);
    rd("scene_keep", `MMCI_REG_SCENE, 32'h7, 32'h4);
    wr(`MMCI_REG_CTRL, 32'h0000_0000);
    u_peer.send(4'hC, 4'hF, 7'h02, 7'h00);
    rd("scene_off", `MMCI_REG_SCENE, 32'h7, 32'h4);
    wr(`MMCI_REG_CTRL, 32'h0000_0081);
    u_peer.send(4'hC, 4'hF, 7'h06, 7'h00);
    repeat (12) @(posedge ref_clk);
    check("halted", {28'h0, `MMCI_HALT_CYC} + 32'h1, halt_cnt);
    check("halt_end", 32'h0, {31'h0, transport_halt});
    rd("scene_play", `MMCI_REG_SCENE, 32'h7, 32'h6);
    rd("resumed", `MMCI_REG_CTRL, 32'h180, 32'h80);
    wr(`MMCI_REG_CTRL, 32'h0000_0101);
    q = halt_cnt;
    u_peer.send(4'hC, 4'hF, 7'h01, 7'h00);
    repeat (12) @(posedge ref_clk);
    check("no_halt", q, halt_cnt);
    rd("scene_rec", `MMCI_REG_SCENE, 32'h7, 32'h6);
    wr(`MMCI_REG_CTRL, 32'h0000_0102);
    for (i = 0; i < 4; i = i + 1)
    begin
      u_peer.send(4'hB, i[3:0], 7'h00, 7'h00);
      u_peer.send(4'hB, i[3:0], 7'h20, 7'h00);
      u_peer.send(4'hC, i[3:0], i[6:0] + 7'h03, 7'h00);
    end
    rd("effect", `MMCI_REG_EFFECT, m_all, 32'h0605_0403);
    u_peer.send(4'hB, 4'h0, 7'h20, 7'h02);
    u_peer.send(4'hC, 4'h0, 7'h0A, 7'h00);
    rd("effect_range", `MMCI_REG_EFFECT, m_all, 32'h0605_0403);
    u_peer.send(4'hC, 4'h0, 7'h09, 7'h00);
    rd("effect_short", `MMCI_REG_EFFECT, m_all, 32'h0605_04D1);
    wr(`MMCI_REG_CTRL, 32'h0000_0100);
    u_peer.send(4'hC, 4'h1, 7'h01, 7'h00);
    rd("effect_off", `MMCI_REG_EFFECT, m_all, 32'h0605_04D1);
    wr(`MMCI_REG_CTRL, 32'h0000_0004);
    u_peer.send(4'hB, 4'h2, 7'h07, 7'h55);
    u_peer.send(4'hB, 4'h5, 7'h07, 7'h11);
    check("fx_param", {4'h4, 7'h07, 7'h55}, {fx_last, fx_param_num, fx_param_val});
    check("fx_count", 32'h1, fx_cnt);
    for (i = 0; i < 5; i = i + 1)
    begin
      wr(`MMCI_REG_CTRL, i < 4 ? i << 5 : 32'h70);
      @(posedge ref_clk);
      check("sync", i < 4 ? (32'h1 << i) >> 1 : 32'h8, {midi_thru_sel, sync_out_w});
    end
    wr(`MMCI_REG_METRO, 32'h7F24_7F96);
    rd("metro_rw", `MMCI_REG_METRO, m_all, 32'h7F24_7F96);
    wr(`MMCI_REG_MSG, 32'h0000_0000);
    rd("velo_min", `MMCI_REG_MSG, m_all, 32'h0000_0081);
    wr(`MMCI_REG_CTRL, 32'h0000_0100);
    tick(1'b1);
    check("click_acc", {4'h9, 7'h24, 7'h01}, u_peer.last_click);
    tick(1'b0);
    check("click_nrm", {4'h9, 7'h7F, 7'h01}, u_peer.last_click);
    wr(`MMCI_REG_CTRL, 32'h0000_0080);
    tick(1'b0);
    check("clicks", 32'h3, u_peer.n_click);
    wr(`MMCI_REG_METRO, 32'h7F24_7F92);
    tick(1'b0);
    check("rec_only", 32'h3, u_peer.n_click);
    wr(`MMCI_REG_METRO, 32'h7F24_7F95);
    tick(1'b0);
    check("int_click", 32'hFF, {int_click_en, int_click_level});
    check("midi_quiet", 32'h3, u_peer.n_click);
    complete_run;
  end
endmodule // tb_top
